// ### rtl/system_clock_mode_control.v
// system clock select and power-mode controller with an AHB-Lite slave
// assumes the core gives a one-cycle halt pulse on this clock; oscillator
// ticks and the wake request arrive from outside and are synchronised here
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`include "clock_mode_map.vh"

module system_clock_mode_control #(
	parameter CNT_WIDTH = 11
) (
	input  wire        clock,
	input  wire        rstn,
	input  wire        clockEn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// core and configuration
	input  wire        haltReq,
	input  wire        wakeReq,
	input  wire        highIsCrystal,
	input  wire        lowIsCrystal,
	input  wire        wdogEnable,
	input  wire        lowVoltageDetectEnable,
	input  wire        displayDriverEnable,
	// oscillators
	input  wire        highOscTick,
	input  wire        lowOscTick,
	output wire        highOscEnable,
	output wire        lowOscEnable,
	// clock tree control
	output wire        cpuRun,
	output wire        sysClkRun,
	output wire        sysUseHigh,
	output wire [2:0]  sysClkDiv,
	output wire [5:0]  powerMode
);

	// ----------------------------------------
	// mode states
	// ----------------------------------------
	localparam [5:0] ST_RUN       = 6'b00_0001;
	localparam [5:0] ST_DEEP      = 6'b00_0010;
	localparam [5:0] ST_SLEEP_SUB = 6'b00_0100;
	localparam [5:0] ST_IDLE_OFF  = 6'b00_1000;
	localparam [5:0] ST_IDLE_ON   = 6'b01_0000;
	localparam [5:0] ST_WAKE      = 6'b10_0000;

	reg  [5:0]  state_q;
	reg  [2:0]  divSel_q;
	reg         fastWake_q;
	reg         idleOnHalt_q;
	reg         highSel_q;
	reg         idleClockKeep_q;
	reg         fastActive_q;
	reg         wakeFromSub_q;
	reg         curHigh_q;
	reg  [2:0]  curDiv_q;
	reg         gate_q;
	reg         addrValid_q;
	reg         addrWrite_q;
	reg  [7:0]  addr_q;
	reg  [31:0] rdata_q;

	reg  [2:0]  wakeSync_q;
	reg  [2:0]  highSync_q;
	reg  [2:0]  lowSync_q;

	wire        highReady;
	wire        lowReady;
	wire [7:0]  modeRead;
	wire [7:0]  modeReset;
	wire [7:0]  ctrlRead;
	wire        wantHigh;
	wire [2:0]  wantDiv;
	wire        targetReady;
	wire        switchNeeded;
	wire        highTick;
	wire        lowTick;
	wire        wakeSeen;
	wire        fastAllowed;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// third stage only feeds the edge detectors, never the first stage
	always @(posedge clock) begin
		if (!rstn) begin
			wakeSync_q <= 3'h0;
			highSync_q <= 3'h0;
			lowSync_q  <= 3'h0;
		end else if (clockEn) begin
			wakeSync_q <= {wakeSync_q[1:0], wakeReq};
			highSync_q <= {highSync_q[1:0], highOscTick};
			lowSync_q  <= {lowSync_q[1:0], lowOscTick};
		end
	end

	assign highTick = highSync_q[1] & ~highSync_q[2];
	assign lowTick  = lowSync_q[1] & ~lowSync_q[2];
	assign wakeSeen = wakeSync_q[1];

	// ----------------------------------------
	// oscillator control and ready flags
	// ----------------------------------------
	// slow mode runs the sub clock with high off; fast wake runs it while high settles
	assign highOscEnable = (state_q == ST_RUN) ?
		(wantHigh | curHigh_q | ~fastActive_q & wantHigh) :
		(state_q == ST_IDLE_ON) ? curHigh_q :
		(state_q == ST_WAKE) ? 1'b1 : 1'b0;
	assign lowOscEnable = (state_q != ST_DEEP);

	osc_ready_counter #(
		.WIDTH (CNT_WIDTH)
	) highCounter (
		.clock       (clock),
		.rstn        (rstn),
		.clockEn     (clockEn),
		.oscOn       (highOscEnable),
		.tick        (highTick),
		.settleCount (highIsCrystal ? `HIGH_XTAL_SETTLE :
			`HIGH_RC_SETTLE),
		.ready       (highReady)
	);

	osc_ready_counter #(
		.WIDTH (CNT_WIDTH)
	) lowCounter (
		.clock       (clock),
		.rstn        (rstn),
		.clockEn     (clockEn),
		.oscOn       (lowOscEnable),
		.tick        (lowTick),
		.settleCount (lowIsCrystal ? `LOW_XTAL_SETTLE :
			`LOW_RC_SETTLE),
		.ready       (lowReady)
	);

	// ----------------------------------------
	// clock source selection
	// ----------------------------------------
	assign wantHigh = highSel_q |
		(divSel_q != `DIV_SUB_A && divSel_q != `DIV_SUB_B);
	// the sub clock has no divider, so its code shows as undivided
	assign wantDiv = (highSel_q | ~wantHigh) ? `DIV_NONE : divSel_q;
	assign targetReady = wantHigh ? highReady : lowReady;
	assign switchNeeded = ~fastActive_q &
		(wantHigh != curHigh_q || (wantHigh && wantDiv != curDiv_q));

	// crystal only, and only if the sub clock stayed alive in power-down
	assign fastAllowed = fastWake_q & highIsCrystal & wakeFromSub_q &
		lowReady;

	// ----------------------------------------
	// power-mode sequencer
	// ----------------------------------------
	always @(posedge clock) begin
		if (!rstn) begin
			state_q       <= ST_WAKE;
			fastActive_q  <= 1'b0;
			wakeFromSub_q <= 1'b0;
			curHigh_q     <= 1'b1;
			curDiv_q      <= `DIV_NONE;
			gate_q        <= 1'b0;
		end else if (clockEn) begin
			case (state_q)
			ST_RUN: begin
				if (haltReq) begin
					// idle with clock keep leaves the gate as it stands
					gate_q <= idleOnHalt_q & idleClockKeep_q & gate_q;
					if (idleOnHalt_q)
						state_q <= idleClockKeep_q ? ST_IDLE_ON :
							ST_IDLE_OFF;
					else if (wdogEnable | lowVoltageDetectEnable |
						displayDriverEnable)
						state_q <= ST_SLEEP_SUB;
					else
						state_q <= ST_DEEP;
				end else if (fastActive_q) begin
					// hand over to the crystal once it has settled
					// gate closes a cycle before the mux moves to the crystal
					if (highReady) begin
						gate_q <= 1'b0;
						if (!gate_q) begin
							fastActive_q <= 1'b0;
							curHigh_q    <= 1'b1;
							curDiv_q     <= `DIV_NONE;
						end
					end
				end else if (switchNeeded) begin
					// break the clock for at least a cycle, then move the mux once the target source is ready
					gate_q <= 1'b0;
					if (!gate_q && targetReady) begin
						curHigh_q <= wantHigh;
						curDiv_q  <= wantDiv;
					end
				end else begin
					gate_q <= 1'b1;
				end
			end
			ST_DEEP, ST_SLEEP_SUB, ST_IDLE_OFF: begin
				if (wakeSeen) begin
					state_q       <= ST_WAKE;
					wakeFromSub_q <= (state_q != ST_DEEP);
				end
			end
			ST_IDLE_ON: begin
				// current source is still on, so peripherals keep a clock
				gate_q <= 1'b1;
				if (wakeSeen)
					state_q <= ST_RUN;
			end
			ST_WAKE: begin
				if (fastAllowed && curHigh_q) begin
					// run from the sub clock while the crystal settles
					state_q      <= ST_RUN;
					fastActive_q <= 1'b1;
					curHigh_q    <= 1'b0;
					gate_q       <= 1'b1;
					wakeFromSub_q <= 1'b0;
				end else if (curHigh_q ? highReady : lowReady) begin
					state_q       <= ST_RUN;
					gate_q        <= 1'b1;
					wakeFromSub_q <= 1'b0;
				end
			end
			default: begin
				state_q <= ST_WAKE;
			end
			endcase
		end
	end

	assign cpuRun     = (state_q == ST_RUN);
	assign sysClkRun  = gate_q &
		(state_q == ST_RUN || state_q == ST_IDLE_ON);
	assign sysUseHigh = curHigh_q;
	assign sysClkDiv  = curDiv_q;
	assign powerMode  = state_q;

	// ----------------------------------------
	// AHB-Lite register slave
	// ----------------------------------------
	// zero wait states, but a frozen block holds the bus off
	assign hreadyout = clockEn;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;
	assign modeReset = `MODE_RESET;

	assign modeRead = {divSel_q, fastWake_q, lowReady, highReady,
		idleOnHalt_q, highSel_q};
	// reset-cause flags live elsewhere and read as zero here
	assign ctrlRead = {idleClockKeep_q, 7'h00};

	always @(posedge clock) begin
		if (!rstn) begin
			addrValid_q     <= 1'b0;
			addrWrite_q     <= 1'b0;
			addr_q          <= 8'h00;
			rdata_q         <= 32'h0000_0000;
			divSel_q        <= modeReset[`MODE_DIV_MSB:`MODE_DIV_LSB];
			fastWake_q      <= modeReset[`MODE_FAST_WAKE_BIT];
			idleOnHalt_q    <= modeReset[`MODE_IDLE_HALT_BIT];
			highSel_q       <= modeReset[`MODE_HIGH_SEL_BIT];
			idleClockKeep_q <= 1'b0;
		end else if (clockEn) begin
			addrValid_q <= hsel & htrans[1] & hready;
			addrWrite_q <= hwrite;
			addr_q      <= haddr;
			rdata_q     <= 32'h0000_0000;
			if (hsel && htrans[1] && hready && !hwrite) begin
				if (haddr == `MODE_REG_OFFSET)
					rdata_q <= {24'h00_0000, modeRead};
				else if (haddr == `CTRL_REG_OFFSET)
					rdata_q <= {24'h00_0000, ctrlRead};
			end
			if (addrValid_q && addrWrite_q) begin
				if (addr_q == `MODE_REG_OFFSET) begin
					divSel_q     <= hwdata[`MODE_DIV_MSB:`MODE_DIV_LSB];
					fastWake_q   <= hwdata[`MODE_FAST_WAKE_BIT];
					idleOnHalt_q <= hwdata[`MODE_IDLE_HALT_BIT];
					highSel_q    <= hwdata[`MODE_HIGH_SEL_BIT];
				end else if (addr_q == `CTRL_REG_OFFSET) begin
					idleClockKeep_q <= hwdata[`CTRL_IDLE_KEEP_BIT];
				end
			end
		end
	end

endmodule

// ### rtl/clock_mode_map.vh
// constants for the system clock and power-mode controller
// assumes inclusion by bare name from the rtl files
`ifndef CLOCK_MODE_MAP_VH
`define CLOCK_MODE_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MODE_REG_OFFSET     8'h00
`define CTRL_REG_OFFSET     8'h04

// ----------------------------------------
// system_clock_mode fields
// ----------------------------------------
`define MODE_HIGH_SEL_BIT   0
`define MODE_IDLE_HALT_BIT  1
`define MODE_HIGH_RDY_BIT   2
`define MODE_LOW_RDY_BIT    3
`define MODE_FAST_WAKE_BIT  4
`define MODE_DIV_LSB        5
`define MODE_DIV_MSB        7
`define MODE_RESET          8'h03

// ----------------------------------------
// clock_idle_and_reset_flags fields
// ----------------------------------------
`define CTRL_IDLE_KEEP_BIT  7
`define CTRL_RESET          8'h00

// ----------------------------------------
// divider select codes
// ----------------------------------------
`define DIV_SUB_A           3'h0
`define DIV_SUB_B           3'h1
`define DIV_NONE            3'h0

// ----------------------------------------
// oscillator settle counts, in oscillator cycles
// ----------------------------------------
`define HIGH_XTAL_SETTLE    11'h0400
`define HIGH_RC_SETTLE      11'h000F
`define LOW_XTAL_SETTLE     11'h0400
`define LOW_RC_SETTLE       11'h0001

`endif

// ### rtl/osc_ready_counter.v
// settle counter that raises a ready flag after a number of oscillator ticks
// assumes tick is a one-cycle pulse already in the clock domain
module osc_ready_counter #(
	parameter WIDTH = 11
) (
	input  wire             clock,
	input  wire             rstn,
	input  wire             clockEn,
	input  wire             oscOn,
	input  wire             tick,
	input  wire [WIDTH-1:0] settleCount,
	output wire             ready
);

	reg [WIDTH-1:0] count_q;
	reg             ready_q;

	assign ready = ready_q;

	// restart from zero whenever the oscillator is off
	always @(posedge clock) begin
		if (!rstn) begin
			count_q <= {WIDTH{1'b0}};
			ready_q <= 1'b0;
		end else if (clockEn) begin
			if (!oscOn) begin
				count_q <= {WIDTH{1'b0}};
				ready_q <= 1'b0;
			end else if (tick && !ready_q) begin
				if (count_q + 1'b1 >= settleCount)
					ready_q <= 1'b1;
				count_q <= count_q + 1'b1;
			end
		end
	end

endmodule

// ### tb/clk_mode_monitor.sv
// port assertions for the clock and power-mode controller
// assumes it is bound into system_clock_mode_control
module clk_mode_monitor #(
	parameter CNT_WIDTH = 11
) (
	input logic       clock,
	input logic       rstn,
	input logic       clockEn,
	input logic       hreadyout,
	input logic       hresp,
	input logic       haltReq,
	input logic       wdogEnable,
	input logic       lowVoltageDetectEnable,
	input logic       displayDriverEnable,
	input logic       highOscEnable,
	input logic       lowOscEnable,
	input logic       cpuRun,
	input logic       sysClkRun,
	input logic       sysUseHigh,
	input logic [2:0] sysClkDiv,
	input logic [5:0] powerMode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// ----
	// assertions
	// ----
	bus_okay_a: assert property (!hresp && hreadyout == clockEn)
		else $error("bus answer not okay");
	halt_enter_a: assert property (
		powerMode == 6'h01 && haltReq && clockEn |=>
		powerMode inside {6'h02, 6'h04, 6'h08, 6'h10})
		else $error("halt did not stop the core");
	deep_refused_a: assert property (
		powerMode == 6'h01 && haltReq && clockEn && (wdogEnable ||
		lowVoltageDetectEnable || displayDriverEnable) |=> powerMode != 6'h02)
		else $error("deepest sleep entered while blocked");
	idle_cpu_off_a: assert property (
		powerMode[4:1] != 4'h0 && $stable(powerMode) |-> !cpuRun)
		else $error("core runs in a halted state");
	idle_clock_a: assert property (
		powerMode == 6'h10 && $stable(powerMode) |-> sysClkRun)
		else $error("clock stopped in idle with keep");
	sleep_gate_a: assert property (
		powerMode[3:1] != 3'h0 && $stable(powerMode) |-> !sysClkRun)
		else $error("clock runs in sleep or clockless idle");
	deep_osc_off_a: assert property (
		powerMode == 6'h02 |-> !lowOscEnable && !highOscEnable)
		else $error("oscillator on in deepest sleep");
	sub_sleep_a: assert property (
		powerMode == 6'h04 |-> lowOscEnable && !highOscEnable)
		else $error("wrong oscillators in sub sleep");
	glitch_free_a: assert property (
		$changed(sysUseHigh) |-> !$past(sysClkRun))
		else $error("source moved with gate open");
	div_code_a: assert property (sysClkDiv != 3'h1)
		else $error("illegal divider code");
	cover property (powerMode == 6'h10);
	cover property (powerMode == 6'h02);
	cover property (powerMode == 6'h04);
	cover property (cpuRun && !sysUseHigh);
endmodule

bind system_clock_mode_control clk_mode_monitor #(
	.CNT_WIDTH(CNT_WIDTH)
) u_clk_mode_monitor (.clock, .rstn, .clockEn, .hreadyout, .hresp,
	.haltReq, .wdogEnable, .lowVoltageDetectEnable, .displayDriverEnable,
	.highOscEnable, .lowOscEnable, .cpuRun, .sysClkRun, .sysUseHigh,
	.sysClkDiv, .powerMode);

// ### tb/osc_partner.sv
// behavioural high and low oscillators
// assumes enables come straight from the controller
module osc_partner (
	input  logic highOscEnable,
	input  logic lowOscEnable,
	output logic highOscTick,
	output logic lowOscTick
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		highOscTick = 1'b0;
		lowOscTick = 1'b0;
	end
	// waveform stands low while disabled, unrelated to the bus clock
	always #20 highOscTick = highOscEnable ? !highOscTick : 1'b0;
	always #73 lowOscTick = lowOscEnable ? !lowOscTick : 1'b0;
endmodule

// ### tb/tb_top.sv
// self-checking bench for the clock and power-mode controller
// assumes the bound monitor and the oscillator model
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 0, rstn = 0, hsel = 0, hwrite = 0, rdPhase = 0;
	logic [7:0]  haddr = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] hwdata = 0, hrdata, r;
	logic        hreadyout, hresp, haltReq = 0, wakeReq = 0;
	logic        highIsCrystal = 0, wdogEnable = 0;
	logic        lowVoltageDetectEnable = 0, displayDriverEnable = 0;
	logic        highOscTick, lowOscTick, highOscEnable, lowOscEnable;
	logic        cpuRun, sysClkRun, sysUseHigh;
	logic [2:0]  sysClkDiv;
	logic [5:0]  powerMode;
	logic [31:0] expQ[$];
	int          n_errors = 0, total_checks = 0;
	logic [7:0]  mv[6] = '{8'h03, 8'h03, 8'h01, 8'h11, 8'h01, 8'h01};
	logic [3:0]  cfg[6] = '{4'h8, 4'h0, 4'h0, 4'h4, 4'h2, 4'h1};
	logic [5:0]  pm[6] = '{6'h10, 6'h08, 6'h02, 6'h04, 6'h04, 6'h04};

	always #5 clock = !clock;

	system_clock_mode_control u_system_clock_mode_control (.clock, .rstn,
		.clockEn(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .haltReq,
		.wakeReq, .highIsCrystal, .lowIsCrystal(1'b0), .wdogEnable,
		.lowVoltageDetectEnable, .displayDriverEnable, .highOscTick,
		.lowOscTick, .highOscEnable, .lowOscEnable, .cpuRun, .sysClkRun,
		.sysUseHigh, .sysClkDiv, .powerMode);
	osc_partner u_osc_partner (.highOscEnable, .lowOscEnable, .highOscTick,
		.lowOscTick);

	// ----
	// tasks
	// ----
	task automatic check(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rdPhase <= !wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rdPhase <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	// read data is compared at the edge closing the data phase
	always @(posedge clock)
		if (rdPhase && hreadyout) check("hrdata", hrdata, expQ.pop_front());
	task automatic waitFor(input logic [5:0] m);
		for (int i = 0; i < 9000 && powerMode !== m; i++) @(posedge clock);
		@(posedge clock);
	endtask
	task automatic halt(input logic [5:0] m);
		@(posedge clock);
		haltReq <= 1'b1;
		@(posedge clock);
		haltReq <= 1'b0;
		repeat (3) @(posedge clock);
		check("powerMode", powerMode, m);
		check("cpuRun", cpuRun, 1'b0);
		wakeReq <= 1'b1;
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----
	// tests
	// ----
	initial begin
		void'($urandom(32'heb3c));
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		waitFor(6'h01);
		check("powerMode", powerMode, 6'h01);
		rd(8'h00, 32'h0000_000F);
		rd(8'h04, 32'h0000_0000);
		r = $urandom;
		bus(1'b1, 8'h04, r);
		rd(8'h04, {24'h0, r[7], 7'h00});
		bus(1'b1, 8'h08, $urandom);
		rd(8'h08, 32'h0000_0000);
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, 8'h00, {24'h0, c[2:0], 5'h00});
			for (int i = 0; i < 900 && sysUseHigh !== (c > 1); i++)
				@(posedge clock);
			repeat (4) @(posedge clock);
			check("sysUseHigh", sysUseHigh, c > 1);
			check("highOscEnable", highOscEnable, c > 1);
			if (c > 1) check("sysClkDiv", sysClkDiv, c);
		end
		bus(1'b1, 8'h00, 32'h0000_0001);
		for (int i = 0; i < 900 && sysClkDiv !== 3'h0; i++) @(posedge clock);
		check("sysUseHigh", sysUseHigh, 1'b1);
		rd(8'h00, 32'h0000_000D);
		foreach (pm[k]) begin
			bus(1'b1, 8'h00, {24'h0, mv[k]});
			bus(1'b1, 8'h04, {24'h0, cfg[k][3], 7'h00});
			{wdogEnable, lowVoltageDetectEnable, displayDriverEnable} <=
				cfg[k][2:0];
			halt(pm[k]);
			check("sysClkRun", sysClkRun, pm[k] == 6'h10);
			check("lowOscEnable", lowOscEnable, pm[k] != 6'h02);
			rd(8'h00, {24'h0, mv[k][7:4], pm[k] != 6'h02, pm[k] == 6'h10,
				mv[k][1:0]});
			waitFor(6'h01);
			wakeReq <= 1'b0;
			check("sysUseHigh", sysUseHigh, 1'b1);
			repeat (6) @(posedge clock);
		end
		// second reset with the crystal as high source
		rstn <= 1'b0;
		highIsCrystal <= 1'b1;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		waitFor(6'h01);
		bus(1'b1, 8'h00, 32'h0000_0011);
		halt(6'h04);
		for (int i = 0; i < 900 && cpuRun !== 1'b1; i++) @(posedge clock);
		wakeReq <= 1'b0;
		check("sysUseHigh", sysUseHigh, 1'b0);
		for (int i = 0; i < 9000 && sysUseHigh !== 1'b1; i++) @(posedge clock);
		check("sysClkDiv", sysClkDiv, 3'h0);
		rd(8'h00, 32'h0000_001D);
		repeat (4) @(posedge clock);
		results;
	end
	initial begin
		#400us;
		n_errors++;
		results;
	end
endmodule
